//--- lock_fuse_pkg.sv
// Constants and types for the lock and fuse protection logic
//-----------------------------------------------------------------------------
// Functional notes
// - Six lock bits, 1 unprogrammed, 0 programmed; only chip erase restores 1. The code also restores them to 1 on srst.
// - Memory lock level 1: no programming lock for parallel or serial access.
// - Level 2: memory programming refused, fuse changes blocked.
// - Level 3: memory programming and verify refused, fuse changes blocked.
// - Both application locks 1: self-program write and table read unrestricted.
// - Application write lock 0: self-program writes to application suppressed.
// - Application read lock 0: boot-section table reads of application blocked.
// - Both boot locks 1: self-program write and table read to boot unrestricted.
// - Boot write lock 0: self-program writes to boot section suppressed.
// - Boot read lock 0: application table reads of boot section blocked.
// - Executing from boot with boot read lock programmed keeps interrupts off.
// - Two-bit boot size field picks boot size and start; default 11.
// - Boot reset fuse 0 vectors to boot start; 1 vectors to zero.
// - Brown-out level fuse picks threshold and start-up; default 1.
// - Brown-out enable fuse 0 turns detector on; default 1.
// - Serial download fuse 0 enables serial programming; default 0; not serially writable.
// - Four-bit clock select picks source and delay; default 0010.
// - Chip erase keeps fuses; fuses locked when first memory lock programmed.
// - Three signature bytes at locations 0 to 2, readable in both modes.
// - Calibration byte read from high byte of signature location 0.
// - Chip erase clears memories and lock bits, locks restored after erase done.
//-----------------------------------------------------------------------------
package lock_fuse_pkg;

    localparam logic [5:0] LOCK_RESET = 6'h3f;
    localparam logic [9:0] FUSE_RESET = 10'h3e2;
    // Fuse field positions in the ten-bit fuse word
    localparam int FUSE_CKSEL_LSB = 0;
    localparam int FUSE_SERIAL_DOWNLOAD_ENABLE_POS = 4;
    localparam int FUSE_BROWNOUT_DETECTOR_ENABLE_POS = 5;
    localparam int FUSE_BODLVL_POS = 6;
    localparam int FUSE_BOOT_RESET_VECTOR_SELECT_POS = 7;
    localparam int FUSE_BOOTSZ_LSB = 8;
    // Lock field positions in the six-bit lock word
    localparam int LOCK_LB1_POS = 0;
    localparam int LOCK_LB2_POS = 1;
    localparam int LOCK_APP_SECTION_WRITE_LOCK_POS = 2;
    localparam int LOCK_APP_SECTION_READ_LOCK_POS = 3;
    localparam int LOCK_BOOT_SECTION_WRITE_LOCK_POS = 4;
    localparam int LOCK_BOOT_SECTION_READ_LOCK_POS = 5;
    // Word addresses of the boot section start for each boot size code
    localparam logic [12:0] BOOT_START_00 = 13'h1c00;
    localparam logic [12:0] BOOT_START_01 = 13'h1e00;
    localparam logic [12:0] BOOT_START_10 = 13'h1f00;
    localparam logic [12:0] BOOT_START_11 = 13'h1f80;
    localparam logic [12:0] RESET_VECTOR_APP = 13'h0000;
    // Chip erase duration in cycles
    localparam logic [15:0] ERASE_CYCLES = 16'h0400;
    // APB register byte offsets
    localparam logic [7:0] ADDR_LOCK = 8'h00;
    localparam logic [7:0] ADDR_FUSE = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_SIG = 8'h10;
    localparam logic [7:0] ADDR_CHECK = 8'h14;
    localparam logic [7:0] ADDR_DECODE = 8'h18;
    // Control register command bits
    localparam int CTRL_WR_LOCK = 0;
    localparam int CTRL_WR_FUSE = 1;
    localparam int CTRL_ERASE = 2;
    localparam int CTRL_SERIAL = 3;

    typedef enum logic [1:0] {ERASE_IDLE, ERASE_BUSY, ERASE_RESTORE} erase_state_type;

endpackage

//--- lock_decode.sv
// Combinational decode of lock and fuse words into protection controls
`timescale 1ns/100ps
module lock_decode
    import lock_fuse_pkg::*;
(
    // Nonvolatile values
    input wire logic [5:0] lockBits,
    input wire logic [9:0] fuseBits,
    // Access check
    input wire logic [12:0] accessAddr,
    input wire logic execFromBoot,
    // Decoded controls
    output logic progLock,
    output logic verifyLock,
    output logic fuseLock,
    output logic appWriteBlock,
    output logic appReadBlock,
    output logic bootWriteBlock,
    output logic bootReadBlock,
    output logic targetBoot,
    output logic irqDisable,
    output logic [12:0] bootStart,
    output logic [12:0] resetVector
);

    always_comb
    begin
        // Level 2 blocks programming, level 3 also verification
        progLock = ~lockBits[LOCK_LB1_POS];
        verifyLock = ~lockBits[LOCK_LB1_POS] & ~lockBits[LOCK_LB2_POS];
        fuseLock = ~lockBits[LOCK_LB1_POS];
        appWriteBlock = ~lockBits[LOCK_APP_SECTION_WRITE_LOCK_POS];
        appReadBlock = ~lockBits[LOCK_APP_SECTION_READ_LOCK_POS];
        bootWriteBlock = ~lockBits[LOCK_BOOT_SECTION_WRITE_LOCK_POS];
        bootReadBlock = ~lockBits[LOCK_BOOT_SECTION_READ_LOCK_POS];
        case (fuseBits[FUSE_BOOTSZ_LSB +: 2])
            2'b00: bootStart = BOOT_START_00;
            2'b01: bootStart = BOOT_START_01;
            2'b10: bootStart = BOOT_START_10;
            default: bootStart = BOOT_START_11;
        endcase
        targetBoot = accessAddr >= bootStart;
        irqDisable = execFromBoot & ~lockBits[LOCK_BOOT_SECTION_READ_LOCK_POS];
        resetVector = fuseBits[FUSE_BOOT_RESET_VECTOR_SELECT_POS] ? RESET_VECTOR_APP : bootStart;
    end

endmodule

//--- lock_fuse_protection_logic.sv
// Lock and fuse store, APB register slave and access gating
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
module lock_fuse_protection_logic
    import lock_fuse_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identification value
    parameter logic [7:0] SIG_BYTE1 = 8'ha5, // Arbitrary identification value
    parameter logic [7:0] SIG_BYTE2 = 8'h3c, // Arbitrary identification value
    parameter logic [7:0] CAL_BYTE = 8'h80
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU program memory access check
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic [12:0] cpuAddr,
    input wire logic cpuExecBoot,
    output logic cpuGrant,
    output logic cpuDeny,
    // Decoded controls
    output logic progLockOut,
    output logic verifyLockOut,
    output logic irqDisableOut,
    output logic [12:0] resetVectorOut,
    output logic [1:0] boot_size_select,
    output logic brownout_threshold_select,
    output logic brownout_detector_enable,
    output logic serial_download_enable,
    output logic [3:0] clock_source_select,
    output logic eraseBusy,
    output logic memoryErase
);

    logic [5:0] lockReg;
    logic [9:0] fuseReg;
    erase_state_type eraseState;
    logic [15:0] eraseCount;
    logic [12:0] checkAddr;
    logic checkExecBoot;
    logic progLock, verifyLock, fuseLock;
    logic appWriteBlock, appReadBlock, bootWriteBlock, bootReadBlock;
    logic targetBoot, irqDisable;
    logic [12:0] bootStart, resetVector;
    logic apbAccess, apbWrite, serialMode;
    logic ctrlWrite, eraseStart, lockWrite, fuseWrite;
    logic accessOk;

    //-------------------------------------------------------------------------
    // Decode
    //-------------------------------------------------------------------------
    // The CPU check address is used while the CPU requests, else address zero
    assign checkAddr = cpuReq ? cpuAddr : 13'h0000;
    assign checkExecBoot = cpuExecBoot;

    lock_decode u_decode
    (
        .lockBits(lockReg),
        .fuseBits(fuseReg),
        .accessAddr(checkAddr),
        .execFromBoot(checkExecBoot),
        .progLock(progLock),
        .verifyLock(verifyLock),
        .fuseLock(fuseLock),
        .appWriteBlock(appWriteBlock),
        .appReadBlock(appReadBlock),
        .bootWriteBlock(bootWriteBlock),
        .bootReadBlock(bootReadBlock),
        .targetBoot(targetBoot),
        .irqDisable(irqDisable),
        .bootStart(bootStart),
        .resetVector(resetVector)
    );

    assign apbAccess = psel & penable;
    assign apbWrite = apbAccess & pwrite;
    assign serialMode = pwdata[CTRL_SERIAL];
    assign ctrlWrite = apbWrite && paddr == ADDR_CTRL;
    assign eraseStart = ctrlWrite && pwdata[CTRL_ERASE];
    assign lockWrite = ctrlWrite && pwdata[CTRL_WR_LOCK] && eraseState == ERASE_IDLE;
    // Fuse writes are refused while the fuses are locked or an erase runs
    assign fuseWrite = ctrlWrite && pwdata[CTRL_WR_FUSE] && !fuseLock
                       && eraseState == ERASE_IDLE;

    //-------------------------------------------------------------------------
    // Lock bits
    //-------------------------------------------------------------------------
    // Writes can only program bits to zero; erase restores them
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            lockReg <= LOCK_RESET;
        else if (eraseState == ERASE_RESTORE)
            lockReg <= LOCK_RESET;
        else if (lockWrite)
            lockReg <= lockReg & pwdata[21:16];
    end

    //-------------------------------------------------------------------------
    // Fuse bits
    //-------------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            fuseReg <= FUSE_RESET;
        else if (fuseWrite)
        begin
            // Serial mode cannot touch the serial download fuse
            if (serialMode)
                fuseReg <= {pwdata[31:27], fuseReg[FUSE_SERIAL_DOWNLOAD_ENABLE_POS], pwdata[25:22]};
            else
                fuseReg <= pwdata[31:22];
        end
    end

    //-------------------------------------------------------------------------
    // Chip erase sequencer
    //-------------------------------------------------------------------------
    // Fuses are untouched; locks restored only after memory erase ends
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            eraseState <= ERASE_IDLE;
        else
        begin
            case (eraseState)
                ERASE_IDLE:
                    if (eraseStart)
                        eraseState <= ERASE_BUSY;
                ERASE_BUSY:
                    if (eraseCount == 16'h0001)
                        eraseState <= ERASE_RESTORE;
                default:
                    eraseState <= ERASE_IDLE;
            endcase
        end
    end

    // Cycles left in the memory erase phase
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            eraseCount <= 16'h0000;
        else if (eraseState == ERASE_IDLE && eraseStart)
            eraseCount <= ERASE_CYCLES;
        else if (eraseState == ERASE_BUSY && eraseCount != 16'h0001)
            eraseCount <= eraseCount - 16'h0001;
    end

    // Busy rises already in the cycle after the erase command lands
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            eraseBusy <= 1'b0;
        else
            eraseBusy <= eraseState != ERASE_IDLE || eraseStart;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            memoryErase <= 1'b0;
        else
            memoryErase <= eraseState == ERASE_BUSY;
    end

    //-------------------------------------------------------------------------
    // CPU access check
    //-------------------------------------------------------------------------
    // Writes obey the target's write lock, reads from the other section the target's read lock
    always_comb
    begin
        if (cpuWrite)
            accessOk = targetBoot ? !bootWriteBlock : !appWriteBlock;
        else if (targetBoot)
            accessOk = cpuExecBoot || !bootReadBlock;
        else
            accessOk = !cpuExecBoot || !appReadBlock;
    end

    // Answer one cycle after the request, from that cycle's check
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cpuGrant <= 1'b0;
        else
            cpuGrant <= cpuReq & accessOk;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cpuDeny <= 1'b0;
        else
            cpuDeny <= cpuReq & ~accessOk;
    end

    //-------------------------------------------------------------------------
    // Decoded outputs
    //-------------------------------------------------------------------------
    // Registered copies of the decoded controls and fuse fields
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            progLockOut <= 1'b0;
        else
            progLockOut <= progLock;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            verifyLockOut <= 1'b0;
        else
            verifyLockOut <= verifyLock;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            irqDisableOut <= 1'b0;
        else
            irqDisableOut <= irqDisable;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            resetVectorOut <= RESET_VECTOR_APP;
        else
            resetVectorOut <= resetVector;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            boot_size_select <= FUSE_RESET[FUSE_BOOTSZ_LSB +: 2];
        else
            boot_size_select <= fuseReg[FUSE_BOOTSZ_LSB +: 2];
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            brownout_threshold_select <= FUSE_RESET[FUSE_BODLVL_POS];
        else
            brownout_threshold_select <= fuseReg[FUSE_BODLVL_POS];
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            brownout_detector_enable <= 1'b0;
        else
            brownout_detector_enable <= ~fuseReg[FUSE_BROWNOUT_DETECTOR_ENABLE_POS];
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            serial_download_enable <= 1'b1;
        else
            serial_download_enable <= ~fuseReg[FUSE_SERIAL_DOWNLOAD_ENABLE_POS];
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            clock_source_select <= FUSE_RESET[FUSE_CKSEL_LSB +: 4];
        else
            clock_source_select <= fuseReg[FUSE_CKSEL_LSB +: 4];
    end

    //-------------------------------------------------------------------------
    // APB read path
    //-------------------------------------------------------------------------
    // Zero-wait slave: pready high in every access phase
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            pready <= 1'b0;
        else
            pready <= psel & ~penable;
    end

    // Writes other than control and reads of unmapped words answer with an error
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            pslverr <= 1'b0;
        else if (psel && !penable && paddr != ADDR_CTRL)
        begin
            if (pwrite)
                pslverr <= 1'b1;
            else if (paddr == ADDR_LOCK || paddr == ADDR_FUSE || paddr == ADDR_STATUS)
                pslverr <= 1'b0;
            else if (paddr == ADDR_SIG || paddr == ADDR_CHECK || paddr == ADDR_DECODE)
                pslverr <= 1'b0;
            else
                pslverr <= 1'b1;
        end
        else
            pslverr <= 1'b0;
    end

    // Read data is captured in the setup cycle and stands in the access phase
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == ADDR_LOCK)
                prdata <= {26'h0000000, lockReg};
            else if (paddr == ADDR_FUSE)
                prdata <= {22'h000000, fuseReg};
            else if (paddr == ADDR_STATUS)
                prdata <= {25'h0000000, irqDisable, bootReadBlock, bootWriteBlock,
                           appReadBlock, appWriteBlock, fuseLock, eraseState != ERASE_IDLE};
            else if (paddr == ADDR_SIG)
                prdata <= {CAL_BYTE, SIG_BYTE2, SIG_BYTE1, SIG_BYTE0};
            else if (paddr == ADDR_DECODE)
                prdata <= {3'h0, resetVector, 3'h0, bootStart};
            else if (paddr == ADDR_CHECK)
                prdata <= {30'h00000000, verifyLock, progLock};
            else
                prdata <= 32'h00000000;
        end
        else
            prdata <= 32'h00000000;
    end

endmodule

//--- lock_fuse_props.sv
// Concurrent checks on the lock and fuse protection ports
`timescale 1ns/100ps
module lock_fuse_props
(
    // Clock, reset and bus
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Access check and decode
    input wire logic cpuReq,
    input wire logic cpuExecBoot,
    input wire logic cpuGrant,
    input wire logic cpuDeny,
    input wire logic progLockOut,
    input wire logic verifyLockOut,
    input wire logic irqDisableOut,
    input wire logic serial_download_enable,
    input wire logic [3:0] clock_source_select,
    input wire logic eraseBusy,
    input wire logic memoryErase
);
    import lock_fuse_pkg::*;
    logic [15:0] eraseCnt;
    logic ctrlWr;
    assign ctrlWr = psel && penable && pwrite && paddr == ADDR_CTRL;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Counts cycles of the running memory erase
    always_ff @(posedge clk_sys)
    begin
        if (srst || !memoryErase)
            eraseCnt <= 16'h0000;
        else
            eraseCnt <= eraseCnt + 16'h0001;
    end
    AST_APB_ANSWER:
        assert property (psel && !penable |=> pready) else $error("Access phase without ready");
    AST_CPU_ANSWER:
        assert property (cpuReq |=> cpuGrant ^ cpuDeny) else $error("Request not answered once");
    AST_CPU_IDLE:
        assert property (!cpuReq |=> !cpuGrant && !cpuDeny) else $error("Answer without request");
    AST_VERIFY_PROG:
        assert property (verifyLockOut |-> progLockOut) else $error("Verify lock alone");
    AST_FUSE_LOCKED:
        assert property (ctrlWr && pwdata[CTRL_WR_FUSE] && progLockOut && !eraseBusy
            |=> $stable(clock_source_select) [*2]) else $error("Locked fuses changed");
    AST_SERIAL_KEEP:
        assert property (ctrlWr && pwdata[CTRL_SERIAL] |=> $stable(serial_download_enable) [*2])
        else $error("Serial write changed download enable");
    AST_ERASE_INSIDE:
        assert property (memoryErase |-> eraseBusy) else $error("Memory erase outside busy");
    AST_ERASE_LENGTH:
        assert property ($fell(memoryErase) && !$past(srst) |-> eraseCnt == ERASE_CYCLES)
        else $error("Memory erase length wrong");
    AST_LOCK_RESTORE:
        assert property ($fell(eraseBusy) |-> ##[0:2] !progLockOut && !verifyLockOut)
        else $error("Locks not restored after erase");
    AST_IRQ_CAUSE:
        assert property (!cpuExecBoot |=> !irqDisableOut) else $error("Interrupts off outside boot");
    COV_DENY: cover property (cpuReq ##1 cpuDeny);
    COV_ERASE: cover property ($fell(eraseBusy));
    COV_IRQ: cover property (irqDisableOut);
endmodule

//--- cpu_access_model.sv
// Behavioural CPU issuing program-memory access checks
`timescale 1ns/100ps
module cpu_access_model
(
    // Clock and command from the bench
    input wire logic clk_sys,
    input wire logic go,
    input wire logic goWrite,
    input wire logic [12:0] goAddr,
    input wire logic goBoot,
    // Requests towards the block
    output logic cpuReq = 1'b0,
    output logic cpuWrite = 1'b0,
    output logic [12:0] cpuAddr = 13'h0000,
    output logic cpuExecBoot = 1'b0
);
    // Idle address and direction toggle so stale values never look valid
    always_ff @(posedge clk_sys)
    begin
        cpuReq <= go;
        cpuWrite <= go ? goWrite : ~cpuWrite;
        cpuAddr <= go ? goAddr : ~cpuAddr;
        cpuExecBoot <= goBoot;
    end
endmodule

//--- tb_top.sv
// Self-checking bench for the lock and fuse protection logic
`timescale 1ns/100ps
module tb_top;
    import lock_fuse_pkg::*;
    // Arbitrary identification and calibration values
    localparam logic [31:0] SIG_WORD = 32'h80c3a55a;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic go = 1'b0;
    logic goWrite = 1'b0;
    logic [12:0] goAddr = 13'h0;
    logic goBoot = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, cpuReq, cpuWrite, cpuExecBoot, cpuGrant, cpuDeny;
    logic progLockOut, verifyLockOut, irqDisableOut, eraseBusy, memoryErase;
    logic bodLvl, bodOn, spiOn;
    logic [1:0] bootSize;
    logic [3:0] ckSel;
    logic [12:0] cpuAddr, resetVectorOut, a;
    logic [5:0] lk;
    logic [9:0] fu;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 32'h4caca3be;
    always #12.5 clk_sys = ~clk_sys;
    lock_fuse_protection_logic #(.SIG_BYTE0(8'h5a), .SIG_BYTE1(8'ha5), .SIG_BYTE2(8'hc3),
        .CAL_BYTE(8'h80)) dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
        .cpuAddr(cpuAddr), .cpuExecBoot(cpuExecBoot), .cpuGrant(cpuGrant), .cpuDeny(cpuDeny),
        .progLockOut(progLockOut), .verifyLockOut(verifyLockOut),
        .irqDisableOut(irqDisableOut), .resetVectorOut(resetVectorOut),
        .boot_size_select(bootSize), .brownout_threshold_select(bodLvl),
        .brownout_detector_enable(bodOn), .serial_download_enable(spiOn),
        .clock_source_select(ckSel), .eraseBusy(eraseBusy), .memoryErase(memoryErase));
    cpu_access_model u_cpu (.clk_sys(clk_sys), .go(go), .goWrite(goWrite), .goAddr(goAddr),
        .goBoot(goBoot), .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
        .cpuExecBoot(cpuExecBoot));
    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [12:0] start_of(input logic [1:0] s);
        case (s)
            2'b00: return BOOT_START_00;
            2'b01: return BOOT_START_01;
            2'b10: return BOOT_START_10;
            default: return BOOT_START_11;
        endcase
    endfunction
    // Expected refusal of one access from the current lock and fuse words
    function automatic logic deny_of(input logic w, input logic [12:0] ad, input logic b);
        logic inBoot;
        inBoot = ad >= start_of(fu[9:8]);
        if (w)
            return inBoot ? !lk[4] : !lk[2];
        return inBoot ? (!b && !lk[5]) : (b && !lk[3]);
    endfunction
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        if (k >= 20)
            n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cpu(input logic w, input logic [12:0] ad, input logic b);
        int k;
        @(posedge clk_sys);
        go <= 1'b1;
        goWrite <= w;
        goAddr <= ad;
        goBoot <= b;
        @(posedge clk_sys);
        go <= 1'b0;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (cpuGrant !== 1'b1 && cpuDeny !== 1'b1 && k < 8);
        check({31'h0, cpuDeny}, {31'h0, deny_of(w, ad, b)});
    endtask
    task automatic check_state();
        logic [12:0] vec;
        vec = fu[7] ? RESET_VECTOR_APP : start_of(fu[9:8]);
        apb(1'b0, ADDR_LOCK, 32'h0);
        check(rd, {26'h0, lk});
        apb(1'b0, ADDR_CHECK, 32'h0);
        check(rd, {30'h0, ~lk[0] & ~lk[1], ~lk[0]});
        check({30'h0, verifyLockOut, progLockOut}, {30'h0, ~lk[0] & ~lk[1], ~lk[0]});
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, {25'h0, goBoot & ~lk[5], ~lk[5:2], ~lk[0], 1'b0});
        apb(1'b0, ADDR_FUSE, 32'h0);
        check(rd, {22'h0, fu});
        check({23'h0, bootSize, bodLvl, bodOn, spiOn, ckSel},
            {23'h0, fu[9:8], fu[6], ~fu[5], ~fu[4], fu[3:0]});
        apb(1'b0, ADDR_DECODE, 32'h0);
        check(rd, {3'h0, vec, 3'h0, start_of(fu[9:8])});
        check({19'h0, resetVectorOut}, {19'h0, vec});
    endtask
    //--------------------------------------------------------------------
    // Main sequence and watchdog
    //--------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        lk = 6'h3f;
        fu = {2'b11, 4'b1110, 4'b0010};
        check_state();
        apb(1'b0, ADDR_SIG, 32'h0);
        check(rd, SIG_WORD);
        apb(1'b0, 8'h1c, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_LOCK, 32'h0);
        check({31'h0, err}, 32'h1);
        for (int r = 0; r < 3; r++)
        begin
            apb(1'b1, ADDR_CTRL, 32'h4);
            repeat (1100) @(posedge clk_sys);
            check({30'h0, eraseBusy, memoryErase}, 32'h0);
            lk = 6'h3f;
            check_state();
            fu = (r == 0) ? 10'h0 : 10'($random(seed));
            apb(1'b1, ADDR_CTRL, {fu, 22'h2});
            check_state();
            apb(1'b1, ADDR_CTRL, {~fu, 22'ha});
            fu = {~fu[9:5], fu[4], ~fu[3:0]};
            check_state();
            lk = (r == 0) ? 6'h00 : 6'($random(seed));
            apb(1'b1, ADDR_CTRL, {10'h0, lk, 16'h1});
            apb(1'b1, ADDR_CTRL, {10'h0, 6'h3f, 16'h1});
            check_state();
            apb(1'b1, ADDR_CTRL, {~fu, 22'h2});
            fu = lk[0] ? ~fu : fu;
            check_state();
            cpu(1'b1, start_of(fu[9:8]) - 13'h1, 1'b0);
            cpu(1'b1, start_of(fu[9:8]), 1'b1);
            cpu(1'b0, start_of(fu[9:8]), 1'b0);
            repeat (8)
            begin
                a = 13'($random(seed));
                if (a[0])
                    a = start_of(fu[9:8]) + {10'h0, a[3:1]} - 13'h4;
                cpu(a[1], a, a[2]);
            end
            cpu(1'b0, 13'h0, 1'b1);
            check({31'h0, irqDisableOut}, {31'h0, ~lk[5]});
        end
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end
endmodule
bind lock_fuse_protection_logic lock_fuse_props props (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .cpuReq(cpuReq), .cpuExecBoot(cpuExecBoot), .cpuGrant(cpuGrant),
    .cpuDeny(cpuDeny), .progLockOut(progLockOut), .verifyLockOut(verifyLockOut),
    .irqDisableOut(irqDisableOut), .serial_download_enable(serial_download_enable),
    .clock_source_select(clock_source_select), .eraseBusy(eraseBusy),
    .memoryErase(memoryErase));
